// >>> hdl/timer8_counter_compare.sv
// 8-bit up/down timer with two compare channels and pin override.
//
// Overview of operation
// - Clock source select zero stops the counter completely.
// - Software can read and write the count at any time.
// - A software count write beats a same-cycle count or clear.
// - Three-bit waveform mode, split over control registers A and B.
// - Count compared with both compare registers every cycle for equality.
// - Match sets the channel flag on the tick; enabled flag requests interrupt.
// - A flag clears when its interrupt is acknowledged.
// - Writing one to a flag bit clears it; zero leaves it.
// - Compare registers are double-buffered in PWM modes only.
// - Buffer is copied to the active register at top of sequence.
// - Software access hits the buffer when buffered, else the active register.
// - Force strobe acts like a match on the wave only, non-PWM.
// - Count write blocks all matches on the next tick, even stopped.
// - Wave registers keep their value across waveform mode changes.
// - Output action bits are unbuffered; take effect on the next clock.
// - Reset clears both wave registers to zero.
// - Nonzero output action puts the wave on the pin in every mode.
// - Pin direction bit still decides whether the pin is driven.
// - Output action zero leaves the wave register unchanged on match.
// - Output action bits never change the counting sequence.
// - Mode zero counts up, never clears, wraps from 0xFF to 0x00.
// - Normal mode sets overflow when the count becomes zero; set only.
// - Bottom is 0x00, max is 0xFF; top is 0xFF or compare A.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module timer8_counter_compare (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // External count source pin
  input wire logic ext_clock_pin,
  // Interrupt requests and acknowledges, bit order overflow, A, B
  output logic [2:0] irq_request,
  input wire logic [2:0] irq_ack,
  // Compare output pins, bit 0 channel A, bit 1 channel B
  output logic [1:0] wave_pin_out,
  output logic [1:0] wave_pin_oe_n
);

  timer8_pkg::control_a_type control_a;
  timer8_pkg::control_b_type control_b;
  timer8_pkg::wave_mode_type mode;
  logic [7:0] count_value;
  logic count_down;
  logic [7:0] compare_value [2];
  logic [7:0] compare_buffer [2];
  logic [2:0] int_mask;
  logic [2:0] flags;
  logic [1:0] port_data;
  logic [1:0] pin_direction_bit;
  logic [1:0] wave_output;
  logic [1:0] next_wave;
  logic [1:0] action [2];
  logic [1:0] force_event;
  logic [1:0] match_event;
  logic [1:0] compare_equal;
  logic [9:0] prescale;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_level;
  logic ext_prev;
  logic timer_tick;
  logic block_match;
  logic pwm_mode;
  logic buffered;
  logic [7:0] top_value;
  logic at_top;
  logic at_bottom;
  logic [7:0] next_count;
  logic next_down;
  logic overflow_event;
  logic count_write;
  logic step;
  logic load_buffer;
  logic [2:0] next_flags;
  logic [2:0] flag_clear;

  // Decode of software writes.
  assign count_write = reg_write && reg_addr == timer8_pkg::ADDR_COUNT;
  assign step = timer_tick && !count_write;

  assign mode = timer8_pkg::wave_mode_type'({
    control_b.waveform_mode_bit2,
    control_a.waveform_mode_bit1,
    control_a.waveform_mode_bit0});
  assign action[0] = control_a.action_a;
  assign action[1] = control_a.action_b;

  // Odd modes are the PWM modes.
  assign pwm_mode = mode[0];
  assign buffered = pwm_mode;

  always_comb begin
    unique case (mode)
      timer8_pkg::MODE_CTC,
      timer8_pkg::MODE_PC_COMPARE,
      timer8_pkg::MODE_FAST_COMPARE: top_value = compare_value[0];
      timer8_pkg::MODE_NORMAL,
      timer8_pkg::MODE_PC_MAX,
      timer8_pkg::MODE_FAST_MAX,
      timer8_pkg::MODE_RESERVED_4,
      timer8_pkg::MODE_RESERVED_6: top_value = timer8_pkg::COUNT_MAX;
    endcase
  end

  assign at_top = count_value == top_value;
  assign at_bottom = count_value == timer8_pkg::COUNT_BOTTOM;

  // External pin synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_level <= 1'b0;
      ext_prev <= 1'b0;
    end else if (ce) begin
      ext_s1 <= ext_clock_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_level <= ext_s3;
      end
      ext_prev <= ext_level;
    end
  end

  // Prescaler runs only while a source is selected.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prescale <= timer8_pkg::RESET_PRESCALE;
    end else if (ce) begin
      if (control_b.clock_source_select == 3'h0) begin
        prescale <= timer8_pkg::RESET_PRESCALE;
      end else begin
        prescale <= prescale + 10'h001;
      end
    end
  end

  // Timer tick selection.
  always_comb begin
    unique case (control_b.clock_source_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = ce;
      3'h2: timer_tick = ce && (prescale & timer8_pkg::PRESCALE_MASK_8)
        == timer8_pkg::PRESCALE_MASK_8;
      3'h3: timer_tick = ce && (prescale & timer8_pkg::PRESCALE_MASK_64)
        == timer8_pkg::PRESCALE_MASK_64;
      3'h4: timer_tick = ce && (prescale & timer8_pkg::PRESCALE_MASK_256)
        == timer8_pkg::PRESCALE_MASK_256;
      3'h5: timer_tick = ce && (prescale & timer8_pkg::PRESCALE_MASK_1024)
        == timer8_pkg::PRESCALE_MASK_1024;
      3'h6: timer_tick = ce && ext_prev && !ext_level;
      3'h7: timer_tick = ce && ext_level && !ext_prev;
    endcase
  end

  // Counting sequence depends on the mode only, never on output actions.
  always_comb begin
    next_count = count_value + timer8_pkg::COUNT_ONE;
    next_down = 1'b0;
    overflow_event = 1'b0;
    unique case (mode)
      timer8_pkg::MODE_NORMAL,
      timer8_pkg::MODE_RESERVED_4,
      timer8_pkg::MODE_RESERVED_6: begin
        overflow_event = count_value == timer8_pkg::COUNT_MAX;
      end
      timer8_pkg::MODE_CTC: begin
        if (at_top) begin
          next_count = timer8_pkg::COUNT_BOTTOM;
        end
        overflow_event = count_value == timer8_pkg::COUNT_MAX;
      end
      timer8_pkg::MODE_FAST_MAX,
      timer8_pkg::MODE_FAST_COMPARE: begin
        if (at_top) begin
          next_count = timer8_pkg::COUNT_BOTTOM;
        end
        overflow_event = at_top;
      end
      timer8_pkg::MODE_PC_MAX,
      timer8_pkg::MODE_PC_COMPARE: begin
        if (count_down) begin
          if (at_bottom) begin
            next_down = 1'b0;
          end else begin
            next_down = 1'b1;
            next_count = count_value - timer8_pkg::COUNT_ONE;
          end
        end else if (at_top) begin
          next_down = 1'b1;
          next_count = count_value - timer8_pkg::COUNT_ONE;
        end
        overflow_event = count_down && count_value == timer8_pkg::COUNT_ONE;
      end
    endcase
  end

  // Counter: software writes override any count or clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_value <= timer8_pkg::RESET_BYTE;
      count_down <= 1'b0;
    end else if (ce) begin
      if (count_write) begin
        count_value <= reg_wdata;
      end else if (step) begin
        count_value <= next_count;
        count_down <= next_down;
      end
    end
  end

  // Match blocking after a count write lasts until the next tick.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      block_match <= 1'b0;
    end else if (ce) begin
      if (count_write) begin
        block_match <= 1'b1;
      end else if (timer_tick) begin
        block_match <= 1'b0;
      end
    end
  end

  assign load_buffer = buffered && step && at_top;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_channel
      logic [3:0] my_addr;
      logic my_write;
      assign my_addr = ch == 0 ? timer8_pkg::ADDR_COMPARE_A
                               : timer8_pkg::ADDR_COMPARE_B;
      assign my_write = reg_write && reg_addr == my_addr;
      assign compare_equal[ch] = count_value == compare_value[ch];
      assign match_event[ch] = step && compare_equal[ch]
        && !block_match;

      // Compare register and its buffer.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          compare_value[ch] <= timer8_pkg::RESET_BYTE;
          compare_buffer[ch] <= timer8_pkg::RESET_BYTE;
        end else if (ce) begin
          if (my_write) begin
            compare_buffer[ch] <= reg_wdata;
          end
          if (my_write && !buffered) begin
            compare_value[ch] <= reg_wdata;
          end else if (load_buffer) begin
            compare_value[ch] <= compare_buffer[ch];
          end
        end
      end

      // Wave generator for this channel.
      always_comb begin
        next_wave[ch] = wave_output[ch];
        if (!pwm_mode) begin
          if (match_event[ch] || force_event[ch]) begin
            unique case (action[ch])
              2'h0: next_wave[ch] = wave_output[ch];
              2'h1: next_wave[ch] = !wave_output[ch];
              2'h2: next_wave[ch] = 1'b0;
              2'h3: next_wave[ch] = 1'b1;
            endcase
          end
        end else if (!mode[1]) begin
          if (match_event[ch]) begin
            unique case (action[ch])
              2'h0: next_wave[ch] = wave_output[ch];
              2'h1: next_wave[ch] = (ch == 0 && mode[2])
                ? !wave_output[ch] : wave_output[ch];
              2'h2: next_wave[ch] = count_down;
              2'h3: next_wave[ch] = !count_down;
            endcase
          end
        end else begin
          if (match_event[ch]) begin
            unique case (action[ch])
              2'h0: next_wave[ch] = wave_output[ch];
              2'h1: next_wave[ch] = (ch == 0 && mode[2])
                ? !wave_output[ch] : wave_output[ch];
              2'h2: next_wave[ch] = 1'b0;
              2'h3: next_wave[ch] = 1'b1;
            endcase
          end
          // The step from top to bottom wins, so a compare at top is steady.
          if (step && at_top && action[ch][1]) begin
            next_wave[ch] = !action[ch][0];
          end
        end
      end

      // Wave register keeps its value across mode changes.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          wave_output[ch] <= 1'b0;
        end else if (ce) begin
          wave_output[ch] <= next_wave[ch];
        end
      end

      // Pin: override by the wave, direction from the port bit.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          wave_pin_out[ch] <= 1'b0;
          wave_pin_oe_n[ch] <= 1'b1;
        end else if (ce) begin
          if (action[ch] != 2'h0) begin
            wave_pin_out[ch] <= next_wave[ch];
          end else begin
            wave_pin_out[ch] <= port_data[ch];
          end
          wave_pin_oe_n[ch] <= !pin_direction_bit[ch];
        end
      end
    end
  endgenerate

  // Force strobes only act in the non-PWM modes.
  always_comb begin
    force_event = 2'b00;
    if (reg_write && reg_addr == timer8_pkg::ADDR_CONTROL_B && !pwm_mode) begin
      force_event[0] = reg_wdata[7];
      force_event[1] = reg_wdata[6];
    end
  end

  // Control and port registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      control_a <= timer8_pkg::control_a_type'(timer8_pkg::RESET_BYTE);
      control_b <= timer8_pkg::control_b_type'(timer8_pkg::RESET_BYTE);
      int_mask <= timer8_pkg::RESET_FLAGS;
      port_data <= 2'b00;
      pin_direction_bit <= 2'b00;
    end else if (ce && reg_write) begin
      unique case (reg_addr)
        timer8_pkg::ADDR_CONTROL_A: begin
          control_a <= timer8_pkg::control_a_type'(reg_wdata);
        end
        timer8_pkg::ADDR_CONTROL_B: begin
          control_b <= timer8_pkg::control_b_type'({2'b00, reg_wdata[5:0]});
        end
        timer8_pkg::ADDR_INT_MASK: int_mask <= reg_wdata[2:0];
        timer8_pkg::ADDR_PORT_CTRL: begin
          port_data <= reg_wdata[1:0];
          pin_direction_bit <= reg_wdata[5:4];
        end
        default: begin
        end
      endcase
    end
  end

  // Flags: hardware set wins over a same-cycle clear.
  always_comb begin
    flag_clear = irq_ack;
    if (reg_write && reg_addr == timer8_pkg::ADDR_FLAGS) begin
      flag_clear = flag_clear | reg_wdata[2:0];
    end
    next_flags = flags & ~flag_clear;
    next_flags[timer8_pkg::FLAG_OVERFLOW] =
      next_flags[timer8_pkg::FLAG_OVERFLOW] | (step && overflow_event);
    next_flags[timer8_pkg::FLAG_MATCH_A] =
      next_flags[timer8_pkg::FLAG_MATCH_A] | match_event[0];
    next_flags[timer8_pkg::FLAG_MATCH_B] =
      next_flags[timer8_pkg::FLAG_MATCH_B] | match_event[1];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags <= timer8_pkg::RESET_FLAGS;
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  // Interrupt requests follow the enabled flags.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_request <= timer8_pkg::RESET_FLAGS;
    end else if (ce) begin
      irq_request <= next_flags & int_mask;
    end
  end

  // Read data stands in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= timer8_pkg::RESET_BYTE;
    end else if (ce) begin
      reg_rdata <= timer8_pkg::RESET_BYTE;
      if (reg_read) begin
        unique case (reg_addr)
          timer8_pkg::ADDR_CONTROL_A: reg_rdata <= control_a;
          timer8_pkg::ADDR_CONTROL_B: reg_rdata <= {2'b00, control_b[5:0]};
          timer8_pkg::ADDR_COUNT: reg_rdata <= count_value;
          timer8_pkg::ADDR_COMPARE_A: begin
            reg_rdata <= buffered ? compare_buffer[0] : compare_value[0];
          end
          timer8_pkg::ADDR_COMPARE_B: begin
            reg_rdata <= buffered ? compare_buffer[1] : compare_value[1];
          end
          timer8_pkg::ADDR_INT_MASK: reg_rdata <= {5'h00, int_mask};
          timer8_pkg::ADDR_FLAGS: reg_rdata <= {5'h00, flags};
          timer8_pkg::ADDR_PORT_CTRL: begin
            reg_rdata <= {2'b00, pin_direction_bit, 2'b00, port_data};
          end
          default: reg_rdata <= timer8_pkg::RESET_BYTE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> pkg/timer8_pkg.sv
// Shared constants, register layout and types of the 8-bit timer.
`default_nettype none

package timer8_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_PORT_CTRL = 4'h7;

  // Field positions in the flag and mask registers.
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;

  // Values after reset.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_FLAGS = 3'h0;
  localparam logic [9:0] RESET_PRESCALE = 10'h000;

  // Counter extremes.
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // Prescaler tap masks: a tick falls where the masked bits are all one.
  localparam logic [9:0] PRESCALE_MASK_8 = 10'h007;
  localparam logic [9:0] PRESCALE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRESCALE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRESCALE_MASK_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PC_MAX = 3'b001,
    MODE_CTC = 3'b010,
    MODE_FAST_MAX = 3'b011,
    MODE_RESERVED_4 = 3'b100,
    MODE_PC_COMPARE = 3'b101,
    MODE_RESERVED_6 = 3'b110,
    MODE_FAST_COMPARE = 3'b111
  } wave_mode_type;

  // Control register A layout.
  typedef struct packed {
    logic [1:0] action_a;
    logic [1:0] action_b;
    logic [1:0] unused;
    logic waveform_mode_bit1;
    logic waveform_mode_bit0;
  } control_a_type;

  // Control register B layout; the force bits are write-only strobes.
  typedef struct packed {
    logic force_a;
    logic force_b;
    logic [1:0] unused;
    logic waveform_mode_bit2;
    logic [2:0] clock_source_select;
  } control_b_type;

endpackage

`default_nettype wire

// >>> sim/pin_load.sv
// Board load on the two compare pins, with a pull-up on each pin.
`timescale 1ns/1ps
`default_nettype none

module pin_load (
  // Pins from the timer
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  // Level seen on the board
  output logic [1:0] level
);
  // An undriven pin floats up to one.
  assign level = pin_out | pin_oe_n;
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench of the 8-bit timer.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_clock_pin = 1'b0;
  logic [2:0] irq_request;
  logic [2:0] irq_ack = 3'h0;
  logic [1:0] wave_pin_out;
  logic [1:0] wave_pin_oe_n;
  logic [1:0] level;
  logic [7:0] d;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Each row: offset, data written, data read back.
  logic [19:0] rows [8] = '{{timer8_pkg::ADDR_CONTROL_A, 8'h00, 8'h00},
    {timer8_pkg::ADDR_COMPARE_A, 8'h5A, 8'h5A},
    {timer8_pkg::ADDR_COMPARE_B, 8'hA5, 8'hA5},
    {timer8_pkg::ADDR_INT_MASK, 8'h05, 8'h05},
    {timer8_pkg::ADDR_PORT_CTRL, 8'h33, 8'h33},
    {timer8_pkg::ADDR_CONTROL_B, 8'hC0, 8'h00},
    {4'h9, 8'hFF, 8'h00},
    {timer8_pkg::ADDR_COUNT, 8'h77, 8'h77}};

  always #4 core_clk = ~core_clk;

  timer8_counter_compare timer8_counter_compare_inst (
    .core_clk(core_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin),
    .irq_request(irq_request), .irq_ack(irq_ack),
    .wave_pin_out(wave_pin_out), .wave_pin_oe_n(wave_pin_oe_n)
  );

  pin_load pin_load_inst (
    .pin_out(wave_pin_out), .pin_oe_n(wave_pin_oe_n), .level(level)
  );

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  // Lets the counter run on every clock for about n cycles, then stops it.
  task automatic run(input int n);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (n) @(posedge core_clk);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
  endtask

  task automatic pins(input logic [1:0] exp);
    repeat (3) @(posedge core_clk);
    chk("pin level", {6'h00, level}, {6'h00, exp});
  endtask

  task automatic done(input string t);
    $display("Test %s finished", t);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rc(a[3:0], 8'h00, "reset value");
    chk("oe after reset", {6'h00, wave_pin_oe_n}, 8'h03);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rc(rows[i][19:16], rows[i][7:0], "table row");
    end
    repeat (20) @(posedge core_clk);
    rc(timer8_pkg::ADDR_COUNT, 8'h77, "stopped count");
    done("table");
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h10);
    wr(timer8_pkg::ADDR_INT_MASK, 8'h07);
    // The count written differs from both compare values.
    wr(timer8_pkg::ADDR_COUNT, 8'hFE);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
    for (int i = 0; i < 60 && irq_request[1] !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    chk("match irq", {7'h00, irq_request[1]}, 8'h01);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
    rc(timer8_pkg::ADDR_FLAGS, 8'h03, "flags after wrap");
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= timer8_pkg::ADDR_COUNT;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    chk("count after wrap", {4'h0, d[7:4]}, 8'h01);
    done("normal count");
    wr(timer8_pkg::ADDR_FLAGS, 8'h02);
    rc(timer8_pkg::ADDR_FLAGS, 8'h01, "write one clear");
    @(posedge core_clk);
    irq_ack <= 3'b001;
    @(posedge core_clk);
    irq_ack <= 3'b000;
    rc(timer8_pkg::ADDR_FLAGS, 8'h00, "ack clear");
    done("flag clear");
    wr(timer8_pkg::ADDR_COUNT, 8'h10);
    run(4);
    rc(timer8_pkg::ADDR_FLAGS, 8'h00, "blocked match");
    done("blocking");
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    wr(timer8_pkg::ADDR_PORT_CTRL, 8'h10);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    pins(2'b11);
    rc(timer8_pkg::ADDR_FLAGS, 8'h00, "force no flag");
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    pins(2'b10);
    wr(timer8_pkg::ADDR_PORT_CTRL, 8'h00);
    pins(2'b11);
    wr(timer8_pkg::ADDR_PORT_CTRL, 8'h10);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h43);
    pins(2'b11);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    pins(2'b11);
    done("force and pins");
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h03);
    wr(timer8_pkg::ADDR_COUNT, 8'h05);
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h20);
    rc(timer8_pkg::ADDR_COMPARE_A, 8'h20, "buffer read");
    run(22);
    rc(timer8_pkg::ADDR_FLAGS, 8'h02, "old compare active");
    wr(timer8_pkg::ADDR_FLAGS, 8'h07);
    wr(timer8_pkg::ADDR_COUNT, 8'hF0);
    run(36);
    rc(timer8_pkg::ADDR_FLAGS, 8'h01, "copy at top");
    done("double buffer");
    wr(timer8_pkg::ADDR_FLAGS, 8'h07);
    // Clear on compare A while channel B toggles; count 0 avoids both values.
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h12);
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h06);
    wr(timer8_pkg::ADDR_COMPARE_B, 8'h03);
    wr(timer8_pkg::ADDR_PORT_CTRL, 8'h20);
    wr(timer8_pkg::ADDR_COUNT, 8'h00);
    pins(2'b01);
    run(5);
    pins(2'b11);
    chk("match irq b", {5'h00, irq_request}, 8'h06);
    rc(timer8_pkg::ADDR_COUNT, 8'h00, "clear at top");
    done("clear on match");
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h02);
    repeat (20) @(posedge core_clk);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
    rc(timer8_pkg::ADDR_COUNT, 8'h02, "prescaled count");
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h07);
    repeat (2) begin
      @(posedge core_clk);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
    rc(timer8_pkg::ADDR_COUNT, 8'h04, "pin edge count");
    done("clock sources");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rc(timer8_pkg::ADDR_COUNT, 8'h00, "count after reset");
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    wr(timer8_pkg::ADDR_PORT_CTRL, 8'h10);
    // Wave A was high before reset, so a low pin shows the register cleared.
    pins(2'b10);
    done("second reset");
    close_out();
  end
endmodule

`default_nettype wire

// >>> sim/timer8_chk.sv
// Port-level assertions for the 8-bit timer.
`timescale 1ns/1ps
`default_nettype none

module timer8_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Interrupts and pins
  input wire logic [2:0] irq_request,
  input wire logic [2:0] irq_ack,
  input wire logic [1:0] wave_pin_out,
  input wire logic [1:0] wave_pin_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic [2:0] mask;
  logic [2:0] src;
  logic [7:0] port;
  logic [7:0] ctla;

  // Copies of the registers, rebuilt from the writes that software makes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask <= 3'h0;
      src <= 3'h0;
      port <= 8'h00;
      ctla <= 8'h00;
    end else if (ce && reg_write) begin
      if (reg_addr == timer8_pkg::ADDR_INT_MASK) mask <= reg_wdata[2:0];
      if (reg_addr == timer8_pkg::ADDR_CONTROL_B) src <= reg_wdata[2:0];
      if (reg_addr == timer8_pkg::ADDR_PORT_CTRL) port <= reg_wdata;
      if (reg_addr == timer8_pkg::ADDR_CONTROL_A) ctla <= reg_wdata;
    end
  end

  sequence stopped_s;
    src == 3'h0 && $past(src) == 3'h0;
  endsequence

  sequence settled_s;
    port == $past(port) && port == $past(port, 2) && ctla == $past(ctla)
      && ctla == $past(ctla, 2);
  endsequence

  read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property ($past(reg_read) && $past(reg_addr[3])
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_masked_a: assert property ((irq_request & ~$past(mask)) == 3'h0)
    else $error("interrupt request while masked");
  stopped_quiet_a: assert property (stopped_s ##1
    $past(mask) == $past(mask, 2) |-> (irq_request & ~$past(irq_request))
    == 3'h0) else $error("flag set while stopped");
  write_clear_a: assert property (stopped_s ##0 (reg_write
    && reg_addr == timer8_pkg::ADDR_FLAGS && reg_wdata[1])
    |-> ##2 !irq_request[1]) else $error("flag write did not clear");
  ack_clear_a: assert property (stopped_s ##0 irq_ack[0]
    |-> ##2 !irq_request[0]) else $error("ack did not clear flag");
  reset_wave_a: assert property ($fell(srst) |-> wave_pin_out == 2'b00)
    else $error("pins not zero after reset");
  pin_enable_a: assert property (settled_s |-> wave_pin_oe_n
    == ~port[5:4]) else $error("pin enable differs from direction");
  port_pass_a: assert property (settled_s ##0 ctla[7:6] == 2'b00
    |-> wave_pin_out[0] == port[0]) else $error("port data not on pin");
endmodule

bind timer8_counter_compare timer8_chk timer8_chk_inst (
  .core_clk(core_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .irq_request(irq_request), .irq_ack(irq_ack),
  .wave_pin_out(wave_pin_out), .wave_pin_oe_n(wave_pin_oe_n)
);

`default_nettype wire
